// ==== hw/canfd_regs_pkg.sv ====
// Package with address map, field positions and reset values of the host register interface.
package canfd_regs_pkg;

  // ****************************************
  // Address map
  // ****************************************
  localparam int          ADDR_W          = 13;
  localparam logic [12:0] CORE_LO         = 13'h0000;
  localparam logic [12:0] CORE_HI         = 13'h00FF;
  localparam logic [12:0] TXMSG_LO        = 13'h0100;
  localparam logic [12:0] TXMSG_HI        = 13'h0FFF;
  localparam logic [12:0] RXMSG_LO        = 13'h1000;
  localparam logic [12:0] RXMSG_HI        = 13'h1FFF;
  localparam int          TX_BUFFERS      = 32;
  localparam int          RX_FIFO_DEPTH   = 32;
  localparam int          RX_FILTERS      = 32;
  localparam int          RX_MAILBOXES    = 48;

  // ****************************************
  // Core register offsets
  // ****************************************
  localparam logic [7:0] OFS_SOFT_RESET   = 8'h00;
  localparam logic [7:0] OFS_MODE         = 8'h04;
  localparam logic [7:0] OFS_NOM_PRESC    = 8'h08;
  localparam logic [7:0] OFS_NOM_TIMING   = 8'h0C;
  localparam logic [7:0] OFS_ERR_CNT      = 8'h10;
  localparam logic [7:0] OFS_ERR_FLAGS    = 8'h14;
  localparam logic [7:0] OFS_CORE_STATE   = 8'h18;
  localparam logic [7:0] OFS_IRQ_PEND     = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h20;
  localparam logic [7:0] OFS_IRQ_ACK      = 8'h24;
  localparam logic [7:0] OFS_TIME_STAMP   = 8'h28;
  localparam logic [7:0] OFS_FAST_PRESC   = 8'h88;
  localparam logic [7:0] OFS_FAST_TIMING  = 8'h8C;
  localparam logic [7:0] OFS_TX_SEND      = 8'h90;
  localparam logic [7:0] OFS_TX_SRV_MASK  = 8'h94;
  localparam logic [7:0] OFS_TX_ABORT     = 8'h98;
  localparam logic [7:0] OFS_TX_ABT_MASK  = 8'h9C;
  localparam logic [7:0] OFS_RX_MBX_A     = 8'hB0;
  localparam logic [7:0] OFS_RX_MBX_B     = 8'hB4;
  localparam logic [7:0] OFS_RX_MBX_C     = 8'hB8;
  localparam logic [7:0] OFS_RX_FULL_LO   = 8'hC0;
  localparam logic [7:0] OFS_RX_FULL_HI   = 8'hC4;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          SRST_BIT        = 0;
  localparam int          CEN_BIT         = 1;
  localparam int          SLEEP_BIT       = 0;
  localparam int          LBACK_BIT       = 1;
  localparam int          ST_CONFIG_BIT   = 0;
  localparam int          ST_LBACK_BIT    = 1;
  localparam int          ST_SLEEP_BIT    = 2;
  localparam int          ST_NORMAL_BIT   = 3;
  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
  localparam logic [31:0] STATE_RESET     = 32'h0000_0001;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;

endpackage

// ==== hw/canfd_host_register_interface.sv ====
// Host register interface and address decode of a CAN FD controller.
`timescale 1ns/1ps
module canfd_host_register_interface
  import canfd_regs_pkg::*;
#(
  parameter int TX_WORDS = 960,
  parameter int RX_WORDS = 1024
) (
  // Clock and reset.
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  // Receive buffer mode strap: one selects mailbox mode.
  input  wire logic              i_rx_mailbox_mode,
  // AXI4-Lite write channels.
  input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic              i_s_axi_awvalid,
  output logic                   o_s_axi_awready,
  input  wire logic [31:0]       i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  input  wire logic              i_s_axi_wvalid,
  output logic                   o_s_axi_wready,
  output logic [1:0]             o_s_axi_bresp,
  output logic                   o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic              i_s_axi_arvalid,
  output logic                   o_s_axi_arready,
  output logic [31:0]            o_s_axi_rdata,
  output logic [1:0]             o_s_axi_rresp,
  output logic                   o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready,
  // Status reported by the protocol engine, asynchronous to i_clk.
  input  wire logic [31:0]       i_engine_err_cnt,
  input  wire logic [31:0]       i_engine_err_set,
  input  wire logic [31:0]       i_engine_irq_set,
  // Transceiver pins.
  input  wire logic              i_can_phy_rx,
  output logic                   o_can_phy_tx,
  // Interrupt and configuration toward the protocol engine.
  output logic                   o_irq_out,
  output logic [31:0]            o_mode_cfg,
  output logic                   o_rx_sampled
);

  initial begin
    if (TX_WORDS < 1 || TX_WORDS > 960 || RX_WORDS < 1 || RX_WORDS > 1024) begin
      $error("Message storage sizes exceed the decoded windows.");
    end
  end

  typedef enum logic [1:0] {ST_IDLE, ST_WRESP, ST_RRESP} bus_state_t;

  typedef struct packed {
    bus_state_t  bus;
    logic        awready;
    logic        wready;
    logic        arready;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic [31:0] soft_reset_ctrl;
    logic [31:0] operating_mode_select;
    logic [31:0] nominal_rate_prescaler;
    logic [31:0] nominal_bit_timing;
    logic [31:0] error_counters;
    logic [31:0] error_flags;
    logic [31:0] core_state;
    logic [31:0] irq_pending;
    logic [31:0] irq_mask;
    logic [31:0] time_stamp;
    logic [31:0] fast_phase_prescaler;
    logic [31:0] fast_phase_bit_timing;
    logic [31:0] tx_send_request;
    logic [31:0] tx_served_irq_mask;
    logic [31:0] tx_abort_request;
    logic [31:0] tx_abort_irq_mask;
    logic [31:0] rx_mailbox_ctrl_a;
    logic [31:0] rx_mailbox_ctrl_b;
    logic [31:0] rx_mailbox_ctrl_c;
    logic [31:0] rx_full_irq_mask_lo;
    logic [31:0] rx_full_irq_mask_hi;
    logic        mailbox;
    logic        mode_caught;
    logic        irq;
    logic        tx_pin;
    logic [1:0]  rx_sync;
    logic [63:0] err_cnt_sync;
    logic [63:0] err_set_sync;
    logic [63:0] irq_set_sync;
  } state_t;

  state_t state;
  state_t next_state;
  logic [1:0] rst_sync;
  logic       rstn;

  // Message storage kept in plain arrays outside the struct so it maps to block memory.
  logic [31:0] tx_mem [TX_WORDS];
  logic [31:0] rx_mem [RX_WORDS];
  logic [31:0] tx_rd;
  logic [31:0] rx_rd;

  // ****************************************
  // Reset release
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rstn = rst_sync[1];

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic mbx_only(input logic [7:0] ofs);
    mbx_only = (ofs >= OFS_RX_MBX_A) && (ofs <= OFS_RX_FULL_HI);
  endfunction

  logic [12:0] wa;
  logic [12:0] ra;
  logic        do_write;
  logic        do_read;
  logic [9:0]  tx_wi;
  logic [9:0]  tx_ri;
  logic [9:0]  rx_wi;
  logic [9:0]  rx_ri;
  assign wa = i_s_axi_awaddr;
  assign ra = i_s_axi_araddr;
  assign do_write = (state.bus == ST_IDLE) && i_s_axi_awvalid && i_s_axi_wvalid;
  assign do_read  = (state.bus == ST_IDLE) && !do_write && i_s_axi_arvalid;
  assign tx_wi = 10'((wa - TXMSG_LO) >> 2);
  assign tx_ri = 10'((ra - TXMSG_LO) >> 2);
  assign rx_wi = 10'((wa - RXMSG_LO) >> 2);
  assign rx_ri = 10'((ra - RXMSG_LO) >> 2);

  // ****************************************
  // Message storage
  // ****************************************
  // transmit message memory
  always_ff @(posedge i_clk) begin
    if (do_write && wa >= TXMSG_LO && wa <= TXMSG_HI && 32'(tx_wi) < TX_WORDS) begin
      tx_mem[tx_wi] <= i_s_axi_wdata;
    end
    if (32'(tx_ri) < TX_WORDS) begin
      tx_rd <= tx_mem[tx_ri];
    end else begin
      tx_rd <= ZERO_WORD;
    end
  end

  // receive memory, FIFO or mailbox layout by software
  always_ff @(posedge i_clk) begin
    if (do_write && wa >= RXMSG_LO && wa <= RXMSG_HI && 32'(rx_wi) < RX_WORDS) begin
      rx_mem[rx_wi] <= i_s_axi_wdata;
    end
    if (32'(rx_ri) < RX_WORDS) begin
      rx_rd <= rx_mem[rx_ri];
    end else begin
      rx_rd <= ZERO_WORD;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [7:0]  wo;
    logic [7:0]  ro;
    logic [31:0] d;
    logic [31:0] core_rd;
    logic        wr_core;
    wo = wa[7:0];
    ro = ra[7:0];
    d = i_s_axi_wdata;
    core_rd = ZERO_WORD;
    next_state = state;
    wr_core = do_write && (wa <= CORE_HI);
    next_state.rx_sync      = {state.rx_sync[0], i_can_phy_rx};
    next_state.err_cnt_sync = {state.err_cnt_sync[31:0], i_engine_err_cnt};
    next_state.err_set_sync = {state.err_set_sync[31:0], i_engine_err_set};
    next_state.irq_set_sync = {state.irq_set_sync[31:0], i_engine_irq_set};
    next_state.error_counters = state.err_cnt_sync[63:32];
    if (!state.mode_caught) begin
      next_state.mailbox = i_rx_mailbox_mode;
      next_state.mode_caught = 1'b1;
    end
    // mailbox-only registers act reserved in FIFO mode
    if (!state.mailbox && mbx_only(wo)) begin
      wr_core = 1'b0;
    end
    // full-word writes; reserved offsets fall through
    if (wr_core) begin
      case (wo)
        OFS_SOFT_RESET:  next_state.soft_reset_ctrl = d;
        OFS_MODE:        next_state.operating_mode_select = d;
        OFS_NOM_PRESC:   next_state.nominal_rate_prescaler = d;
        OFS_NOM_TIMING:  next_state.nominal_bit_timing = d;
        OFS_IRQ_MASK:    next_state.irq_mask = d;
        OFS_TIME_STAMP:  next_state.time_stamp = d;
        OFS_FAST_PRESC:  next_state.fast_phase_prescaler = d;
        OFS_FAST_TIMING: next_state.fast_phase_bit_timing = d;
        OFS_TX_SEND:     next_state.tx_send_request = d;
        OFS_TX_SRV_MASK: next_state.tx_served_irq_mask = d;
        OFS_TX_ABORT:    next_state.tx_abort_request = d;
        OFS_TX_ABT_MASK: next_state.tx_abort_irq_mask = d;
        OFS_RX_MBX_A:    next_state.rx_mailbox_ctrl_a = d;
        OFS_RX_MBX_B:    next_state.rx_mailbox_ctrl_b = d;
        OFS_RX_MBX_C:    next_state.rx_mailbox_ctrl_c = d;
        OFS_RX_FULL_LO:  next_state.rx_full_irq_mask_lo = d;
        OFS_RX_FULL_HI:  next_state.rx_full_irq_mask_hi = d;
        default: ;
      endcase
    end
    // write one to clear, new events win
    if (wr_core && wo == OFS_ERR_FLAGS) begin
      next_state.error_flags = state.error_flags & ~d;
    end
    next_state.error_flags = next_state.error_flags | state.err_set_sync[63:32];
    if (wr_core && wo == OFS_IRQ_ACK) begin
      next_state.irq_pending = state.irq_pending & ~d;
    end
    next_state.irq_pending = next_state.irq_pending | state.irq_set_sync[63:32];
    // Soft reset clears mode select, error flags, pending interrupts and its own register; other core registers keep their values.
    if (next_state.soft_reset_ctrl[SRST_BIT]) begin
      next_state.operating_mode_select = ZERO_WORD;
      next_state.error_flags = ZERO_WORD;
      next_state.irq_pending = ZERO_WORD;
      next_state.soft_reset_ctrl = ZERO_WORD;
    end
    next_state.core_state = ZERO_WORD;
    next_state.core_state[ST_CONFIG_BIT] = !state.soft_reset_ctrl[CEN_BIT];
    next_state.core_state[ST_SLEEP_BIT] = state.soft_reset_ctrl[CEN_BIT]
                                          && state.operating_mode_select[SLEEP_BIT];
    next_state.core_state[ST_LBACK_BIT] = state.soft_reset_ctrl[CEN_BIT]
                                          && state.operating_mode_select[LBACK_BIT];
    next_state.core_state[ST_NORMAL_BIT] = state.soft_reset_ctrl[CEN_BIT]
                                           && state.operating_mode_select[1:0] == 2'h0;
    // level interrupt held while any enabled cause is pending
    next_state.irq = |(state.irq_pending & state.irq_mask);
    // recessive transmit idle; loopback keeps the pin recessive
    next_state.tx_pin = 1'b1;
    case (ro)
      OFS_SOFT_RESET:  core_rd = state.soft_reset_ctrl;
      OFS_MODE:        core_rd = state.operating_mode_select;
      OFS_NOM_PRESC:   core_rd = state.nominal_rate_prescaler;
      OFS_NOM_TIMING:  core_rd = state.nominal_bit_timing;
      OFS_ERR_CNT:     core_rd = state.error_counters;
      OFS_ERR_FLAGS:   core_rd = state.error_flags;
      OFS_CORE_STATE:  core_rd = state.core_state;
      OFS_IRQ_PEND:    core_rd = state.irq_pending;
      OFS_IRQ_MASK:    core_rd = state.irq_mask;
      OFS_TIME_STAMP:  core_rd = state.time_stamp;
      OFS_FAST_PRESC:  core_rd = state.fast_phase_prescaler;
      OFS_FAST_TIMING: core_rd = state.fast_phase_bit_timing;
      OFS_TX_SEND:     core_rd = state.tx_send_request;
      OFS_TX_SRV_MASK: core_rd = state.tx_served_irq_mask;
      OFS_TX_ABORT:    core_rd = state.tx_abort_request;
      OFS_TX_ABT_MASK: core_rd = state.tx_abort_irq_mask;
      OFS_RX_MBX_A:    core_rd = state.rx_mailbox_ctrl_a;
      OFS_RX_MBX_B:    core_rd = state.rx_mailbox_ctrl_b;
      OFS_RX_MBX_C:    core_rd = state.rx_mailbox_ctrl_c;
      OFS_RX_FULL_LO:  core_rd = state.rx_full_irq_mask_lo;
      OFS_RX_FULL_HI:  core_rd = state.rx_full_irq_mask_hi;
      default:         core_rd = ZERO_WORD;
    endcase
    if (!state.mailbox && mbx_only(ro)) begin
      core_rd = ZERO_WORD;
    end
    next_state.awready = 1'b0;
    next_state.wready = 1'b0;
    next_state.arready = 1'b0;
    case (state.bus)
      ST_IDLE: begin
        if (do_write) begin
          next_state.awready = 1'b1;
          next_state.wready = 1'b1;
          next_state.bvalid = 1'b1;
          next_state.bus = ST_WRESP;
        end else if (do_read) begin
          next_state.arready = 1'b1;
          next_state.rdata = core_rd;
          next_state.bus = ST_RRESP;
        end
      end
      ST_WRESP: begin
        if (state.bvalid && i_s_axi_bready) begin
          next_state.bvalid = 1'b0;
          next_state.bus = ST_IDLE;
        end
      end
      ST_RRESP: begin
        if (!state.rvalid) begin
          next_state.rvalid = 1'b1;
          if (ra >= TXMSG_LO && ra <= TXMSG_HI) begin
            next_state.rdata = tx_rd;
          end else if (ra >= RXMSG_LO) begin
            next_state.rdata = rx_rd;
          end
        end else if (i_s_axi_rready) begin
          next_state.rvalid = 1'b0;
          next_state.bus = ST_IDLE;
        end
      end
      default: next_state.bus = ST_IDLE;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
      state.bus <= ST_IDLE;
      state.core_state <= STATE_RESET;
      state.tx_pin <= 1'b1;
      state.rx_sync <= 2'h3;
    end else begin
      state <= next_state;
    end
  end

  // bus handshake, read data and interrupt from i_clk flip-flops; both responses tied to OKAY
  assign o_s_axi_awready = state.awready;
  assign o_s_axi_wready  = state.wready;
  assign o_s_axi_bvalid  = state.bvalid;
  assign o_s_axi_bresp   = RESP_OKAY;
  assign o_s_axi_arready = state.arready;
  assign o_s_axi_rvalid  = state.rvalid;
  assign o_s_axi_rdata   = state.rdata;
  assign o_s_axi_rresp   = RESP_OKAY;
  assign o_irq_out       = state.irq;
  assign o_can_phy_tx    = state.tx_pin;
  assign o_mode_cfg      = state.operating_mode_select;
  assign o_rx_sampled    = state.rx_sync[1];

endmodule

// ==== dv/canfd_host_chk.sv ====
// Assertion checker on the ports of the host register interface.
`timescale 1ns/1ps
module canfd_host_chk
  import canfd_regs_pkg::*;
(
  // Clock and reset.
  input wire logic        i_clk,
  input wire logic        i_rstn,
  // Bus handshake.
  input wire logic        i_s_axi_awvalid,
  input wire logic        i_s_axi_wvalid,
  input wire logic        i_s_axi_bready,
  input wire logic        i_s_axi_rready,
  input wire logic        o_s_axi_awready,
  input wire logic        o_s_axi_wready,
  input wire logic [1:0]  o_s_axi_bresp,
  input wire logic        o_s_axi_bvalid,
  input wire logic        o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0]  o_s_axi_rresp,
  input wire logic        o_s_axi_rvalid,
  // Pins.
  input wire logic        i_can_phy_rx,
  input wire logic        o_can_phy_tx,
  input wire logic        o_irq_out,
  input wire logic        o_rx_sampled
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  a_bresp_okay: assert property (o_s_axi_bvalid |-> o_s_axi_bresp == RESP_OKAY)
    else $error("write response not OKAY");
  a_rresp_okay: assert property (o_s_axi_rvalid |-> o_s_axi_rresp == RESP_OKAY)
    else $error("read response not OKAY");
  a_ready_pair: assert property (o_s_axi_awready == o_s_axi_wready)
    else $error("address and data ready differ");
  a_ready_pulse: assert property (o_s_axi_awready |=> !o_s_axi_awready)
    else $error("write ready longer than one cycle");
  a_write_cause: assert property ($rose(o_s_axi_bvalid) |-> $past(i_s_axi_awvalid && i_s_axi_wvalid))
    else $error("write response without a write");
  a_read_latency: assert property (o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read data late");
  a_rvalid_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped before accepted");
  a_bvalid_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
    else $error("write response dropped before accepted");
  a_one_pending: assert property (o_s_axi_rvalid |-> !o_s_axi_bvalid && !o_s_axi_awready)
    else $error("two transactions outstanding");
  a_tx_idle: assert property (o_can_phy_tx == 1'b1)
    else $error("transmit pin not recessive");
  a_irq_level: assert property (o_irq_out && !o_s_axi_bvalid && !$past(o_s_axi_bvalid) |=> o_irq_out)
    else $error("interrupt fell without a register write");
  a_rx_sync: assert property ($stable(i_can_phy_rx) [*8] |-> o_rx_sampled == i_can_phy_rx)
    else $error("receive pin not followed");

  c_write: cover property (o_s_axi_bvalid && i_s_axi_bready);
  c_read_slow: cover property (o_s_axi_rvalid && !i_s_axi_rready);
  c_irq: cover property ($rose(o_irq_out));
endmodule

bind canfd_host_register_interface canfd_host_chk canfd_host_chk_i (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_s_axi_awvalid(i_s_axi_awvalid),
  .i_s_axi_wvalid(i_s_axi_wvalid), .i_s_axi_bready(i_s_axi_bready),
  .i_s_axi_rready(i_s_axi_rready), .o_s_axi_awready(o_s_axi_awready),
  .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp),
  .o_s_axi_bvalid(o_s_axi_bvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp),
  .o_s_axi_rvalid(o_s_axi_rvalid), .i_can_phy_rx(i_can_phy_rx),
  .o_can_phy_tx(o_can_phy_tx), .o_irq_out(o_irq_out), .o_rx_sampled(o_rx_sampled)
);

// ==== dv/axil_host_model.sv ====
// Host model issuing single register transfers, promptly or with late response acceptance.
`timescale 1ns/1ps
module axil_host_model
  import canfd_regs_pkg::*;
(
  // Clock.
  input  wire logic              i_clk,
  // Write channels.
  output logic [ADDR_W-1:0]      o_awaddr,
  output logic                   o_awvalid,
  input  wire logic              i_awready,
  output logic [31:0]            o_wdata,
  output logic [3:0]             o_wstrb,
  output logic                   o_wvalid,
  input  wire logic [1:0]        i_bresp,
  input  wire logic              i_bvalid,
  output logic                   o_bready,
  // Read channels.
  output logic [ADDR_W-1:0]      o_araddr,
  output logic                   o_arvalid,
  input  wire logic              i_arready,
  input  wire logic [31:0]       i_rdata,
  input  wire logic [1:0]        i_rresp,
  input  wire logic              i_rvalid,
  output logic                   o_rready
);
  logic slow = 1'b0;

  initial begin
    {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
    {o_araddr, o_arvalid, o_rready} = '0;
  end

  // Released address and data lines show the inverse of their last value; the write strobes keep theirs.
  task automatic wr(input logic [12:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge i_clk);
    #1;
    o_awaddr = a;
    o_wdata = d;
    o_wstrb = a[5:2];
    o_awvalid = 1'b1;
    o_wvalid = 1'b1;
    o_bready = !slow;
    do begin @(negedge i_clk); n++; end while (!i_awready && n < 20);
    resp = (n < 20 && i_bvalid) ? i_bresp : 2'bxx;
    @(posedge i_clk);
    #1;
    o_awvalid = 1'b0;
    o_wvalid = 1'b0;
    o_awaddr = ~a;
    o_wdata = ~d;
    if (slow) begin
      repeat (2) @(posedge i_clk);
      #1;
      o_bready = 1'b1;
      @(posedge i_clk);
      #1;
    end
    o_bready = 1'b0;
  endtask

  task automatic rd(input logic [12:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge i_clk);
    #1;
    o_araddr = a;
    o_arvalid = 1'b1;
    o_rready = !slow;
    do begin @(negedge i_clk); n++; end while (!i_arready && n < 20);
    @(posedge i_clk);
    #1;
    o_arvalid = 1'b0;
    o_araddr = ~a;
    while (!i_rvalid && n < 20) begin @(negedge i_clk); n++; end
    if (slow) begin
      repeat (3) @(posedge i_clk);
      #1;
      o_rready = 1'b1;
    end
    d = (n < 20) ? i_rdata : 'x;
    resp = (n < 20) ? i_rresp : 2'bxx;
    @(posedge i_clk);
    #1;
    o_rready = 1'b0;
  endtask
endmodule

// ==== dv/canfd_host_register_interface_bench.sv ====
// Self-checking testbench of the CAN FD host register interface.
`timescale 1ns/1ps
module canfd_host_register_interface_bench
  import canfd_regs_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, mbx = 1'b0, phy_rx = 1'b1, phy_tx, irq, rx_smp;
  logic awv, awr, wv, wr_rdy, bv, brd, arv, arr, rv, rrd;
  logic [12:0] awa, ara;
  logic [31:0] wd, rd, err_cnt = '0, err_set = '0, irq_set = '0, mode_cfg;
  logic [3:0] ws;
  logic [1:0] br, rr;
  int num_errors = 0, compares = 0;
  logic [7:0] rw_ofs [8] = '{OFS_NOM_PRESC, OFS_NOM_TIMING, OFS_TIME_STAMP, OFS_FAST_PRESC,
                             OFS_FAST_TIMING, OFS_TX_SRV_MASK, OFS_TX_ABT_MASK, OFS_IRQ_MASK};
  logic [7:0] mb_ofs [5] = '{OFS_RX_MBX_A, OFS_RX_MBX_B, OFS_RX_MBX_C, OFS_RX_FULL_LO,
                             OFS_RX_FULL_HI};
  logic [7:0] rsv_ofs [7] = '{8'h2C, 8'h84, 8'hA0, 8'hAC, 8'hBC, 8'hC8, 8'hDC};

  always #2 clk = ~clk;

  canfd_host_register_interface canfd_host_register_interface_i (
    .i_clk(clk), .i_rstn(rstn), .i_rx_mailbox_mode(mbx), .i_s_axi_awaddr(awa),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_rdy), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(brd), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rrd),
    .i_engine_err_cnt(err_cnt), .i_engine_err_set(err_set), .i_engine_irq_set(irq_set),
    .i_can_phy_rx(phy_rx), .o_can_phy_tx(phy_tx), .o_irq_out(irq), .o_mode_cfg(mode_cfg),
    .o_rx_sampled(rx_smp)
  );

  axil_host_model axil_host_model_i (
    .i_clk(clk), .o_awaddr(awa), .o_awvalid(awv), .i_awready(awr), .o_wdata(wd), .o_wstrb(ws),
    .o_wvalid(wv), .i_bresp(br), .i_bvalid(bv), .o_bready(brd), .o_araddr(ara),
    .o_arvalid(arv), .i_arready(arr), .i_rdata(rd), .i_rresp(rr), .i_rvalid(rv), .o_rready(rrd)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wreg(input logic [7:0] hi, input logic [7:0] lo, input logic [31:0] d);
    logic [1:0] r;
    axil_host_model_i.wr({hi[4:0], lo}, d, r);
    chk("bresp", 32'h0, {30'h0, r});
  endtask

  task automatic rchk(input string s, input logic [7:0] hi, input logic [7:0] lo,
                      input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axil_host_model_i.rd({hi[4:0], lo}, d, r);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    chk(s, exp, d);
  endtask

  task automatic do_reset(input logic m);
    rstn = 1'b0;
    mbx = m;
    wait_cy(6);
    rstn = 1'b1;
    wait_cy(3);
  endtask

  task automatic t_reset();
    chk("irq_out", 32'h0, {31'h0, irq});
    chk("phy_tx", 32'h1, {31'h0, phy_tx});
    rchk("core_state", 8'h0, OFS_CORE_STATE, STATE_RESET);
    $display("reset test done");
  endtask

  task automatic t_rw();
    for (int i = 0; i < 8; i++)
      wreg(8'h0, rw_ofs[i], 32'hC3A5_9600 + i);
    for (int i = 0; i < 8; i++)
      rchk("rw register", 8'h0, rw_ofs[i], 32'hC3A5_9600 + i);
    wreg(8'h0, OFS_IRQ_MASK, ZERO_WORD);
    wreg(8'h0, OFS_MODE, 32'h0000_0002);
    wait_cy(2);
    chk("mode_cfg", 32'h0000_0002, mode_cfg);
    wreg(8'h0, OFS_SOFT_RESET, 32'h0000_0002);
    rchk("core_state", 8'h0, OFS_CORE_STATE, 32'h0000_0002);
    wreg(8'h0, OFS_SOFT_RESET, 32'h0000_0001);
    rchk("soft_reset_ctrl", 8'h0, OFS_SOFT_RESET, ZERO_WORD);
    rchk("operating_mode_select", 8'h0, OFS_MODE, ZERO_WORD);
    chk("mode_cfg", ZERO_WORD, mode_cfg);
    $display("read write test done");
  endtask

  task automatic t_reserved(input logic mb);
    for (int i = 0; i < 7; i++) begin
      wreg(8'h0, rsv_ofs[i], 32'hFFFF_FFFF);
      rchk("reserved", 8'h0, rsv_ofs[i], ZERO_WORD);
    end
    for (int i = 0; i < 5; i++) begin
      wreg(8'h0, mb_ofs[i], 32'h6B00_0000 + i);
      rchk("mailbox reg", 8'h0, mb_ofs[i], mb ? 32'h6B00_0000 + i : ZERO_WORD);
    end
    $display("reserved test done");
  endtask

  task automatic t_status();
    err_cnt = 32'h0000_1234;
    err_set = 32'h0000_0005;
    wait_cy(8);
    err_set = ZERO_WORD;
    wait_cy(8);
    wreg(8'h0, OFS_ERR_CNT, 32'hFFFF_FFFF);
    rchk("error_counters", 8'h0, OFS_ERR_CNT, 32'h0000_1234);
    rchk("error_flags", 8'h0, OFS_ERR_FLAGS, 32'h0000_0005);
    wreg(8'h0, OFS_ERR_FLAGS, 32'h0000_0001);
    rchk("error_flags", 8'h0, OFS_ERR_FLAGS, 32'h0000_0004);
    $display("status test done");
  endtask

  task automatic t_irq();
    irq_set = 32'h0000_0001;
    wait_cy(8);
    irq_set = ZERO_WORD;
    wait_cy(8);
    chk("irq masked", 32'h0, {31'h0, irq});
    rchk("irq_pending", 8'h0, OFS_IRQ_PEND, 32'h0000_0001);
    wreg(8'h0, OFS_IRQ_MASK, 32'h0000_0001);
    wait_cy(6);
    chk("irq raised", 32'h1, {31'h0, irq});
    wreg(8'h0, OFS_IRQ_ACK, 32'h0000_0001);
    wait_cy(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rchk("irq_acknowledge", 8'h0, OFS_IRQ_ACK, ZERO_WORD);
    $display("interrupt test done");
  endtask

  task automatic t_ram();
    logic [12:0] a [4] = '{13'h0100, 13'h0FFC, 13'h1000, 13'h1FFC};
    axil_host_model_i.slow = 1'b1;
    for (int i = 0; i < 4; i++)
      wreg({3'h0, a[i][12:8]}, a[i][7:0], 32'h1357_0000 + i);
    for (int i = 0; i < 4; i++)
      rchk("message ram", {3'h0, a[i][12:8]}, a[i][7:0], 32'h1357_0000 + i);
    axil_host_model_i.slow = 1'b0;
    $display("message ram test done");
  endtask

  task automatic t_phy();
    phy_rx = 1'b0;
    wait_cy(10);
    chk("rx_sampled", 32'h0, {31'h0, rx_smp});
    phy_rx = 1'b1;
    wait_cy(10);
    chk("rx_sampled", 32'h1, {31'h0, rx_smp});
    chk("phy_tx", 32'h1, {31'h0, phy_tx});
    $display("pin test done");
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #100_000;
    num_errors++;
    $display("[ERR] watchdog expected finish seen hang");
    end_sim();
  end

  initial begin
    do_reset(1'b0);
    t_reset();
    t_rw();
    t_reserved(1'b0);
    t_status();
    t_irq();
    t_ram();
    t_phy();
    do_reset(1'b1);
    t_reset();
    t_reserved(1'b1);
    end_sim();
  end
endmodule
